// ==== design/lvc_pkg.sv ====
// lvc_pkg: constants and types for the lcd drive-voltage control block
//
// Contract
// - pump on/off follows pump enable bit
// - multiplier bit: 0 doubles, 1 triples supply
// - drive code is programmed plus signed offset
// - target voltage is code times 0.03 plus 3
// - any programmed code 00 to ff accepted
// - drive voltage capped at 9.0 volts
// - external supply: no temperature compensation applied
// - external supply: programmed code changes nothing
// - frequency bit 0 full rate, 1 half
// - readable 8-bit temperature code held
// - measurements repeat while enabled, 5 ms each
// - measurement interval counted from system clock
// - filter bit off by default, raw value used
// - filtered value starts at 20 degrees
// - sum clamps at both ends of range
// - reset: programmed zero, temperature code 40h
// - offset added only with compensation enabled
package lvc_pkg;
   // register indices on the plain register port
   localparam logic [2:0] REG_CTRL   = 3'h0;
   localparam logic [2:0] REG_VOLT   = 3'h1;
   localparam logic [2:0] REG_TEMP   = 3'h2;
   localparam logic [2:0] REG_OFFS   = 3'h3;
   localparam logic [2:0] REG_DRIVE  = 3'h4;
   localparam logic [2:0] REG_STATUS = 3'h5;

   // control field positions
   localparam int CTRL_PUMP_EN   = 0;
   localparam int CTRL_MULT      = 1;
   localparam int CTRL_FREQ      = 2;
   localparam int CTRL_MEAS_EN   = 3;
   localparam int CTRL_FILTER_EN = 4;
   localparam int CTRL_COMP_EN   = 5;
   localparam int CTRL_EXT_SUP   = 6;
   localparam int CTRL_WIDTH     = 7;

   // reset values
   localparam logic [6:0] CTRL_RESET = 7'h00;
   localparam logic [7:0] VOLT_RESET = 8'h00;
   localparam logic [7:0] TEMP_RESET = 8'h40;

   // voltage scaling in millivolts
   localparam int LCD_DRIVE_VOLTAGE_BASE_MV = 3000;
   localparam int LCD_DRIVE_VOLTAGE_STEP_MV = 30;
   localparam int LCD_DRIVE_VOLTAGE_MAX_MV  = 9000;
   localparam logic [7:0] DRIVE_CAP_CODE =
      8'((LCD_DRIVE_VOLTAGE_MAX_MV - LCD_DRIVE_VOLTAGE_BASE_MV) / LCD_DRIVE_VOLTAGE_STEP_MV);

   // timing
   localparam int CLK_MHZ         = 250;
   localparam int MEAS_TIME_US    = 5000;
   localparam int INTERVAL_MS     = 3300;
   localparam int MEAS_CYCLES     = MEAS_TIME_US * CLK_MHZ;
   localparam int INTERVAL_CYCLES = INTERVAL_MS * 1000 * CLK_MHZ;
   localparam int PUMP_DIV_CYCLES = 64;
   localparam int FILTER_SHIFT    = 2;

   typedef struct packed {
      logic ext_supply;
      logic comp_en;
      logic filter_en;
      logic meas_en;
      logic freq_sel;
      logic mult_sel;
      logic pump_en;
   } lvc_ctrl_t;

   typedef struct packed {
      logic clk;
      logic frequency_select;
      logic multiplier_select;
      logic enable;
   } lvc_pump_t;

   typedef enum logic [1:0] {
      LVC_IDLE = 2'b00,
      LVC_CONV = 2'b01,
      LVC_WAIT = 2'b10
   } lvc_meas_t;
endpackage

// ==== design/lvc_top.sv ====
// lvc_top: drive-voltage code, pump control and temperature measurement
`timescale 1ns/1ns
module lvc_top #(
   parameter int unsigned MEAS_CYC     = lvc_pkg::MEAS_CYCLES,
   parameter int unsigned INTERVAL_CYC = lvc_pkg::INTERVAL_CYCLES,
   parameter int unsigned PUMP_DIV     = lvc_pkg::PUMP_DIV_CYCLES
) (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             reset_n,
   // register port
   input  wire logic [2:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   input  wire logic             reg_write,
   input  wire logic             reg_read,
   output logic [7:0]            reg_rdata,
   // temperature sensor
   output logic                  sense_start,
   input  wire logic [7:0]       sense_value,
   // charge pump and regulator
   output lvc_pkg::lvc_pump_t    pump_ctrl,
   output logic [7:0]            drive_code,
   output logic [13:0]           lcd_drive_voltage
);

   ////////////////////////////////////////////////////////////////////////
   // registers
   lvc_pkg::lvc_ctrl_t  ctrl_ff;
   logic [7:0]          programmed_voltage_code_ff;
   logic [7:0]          temperature_code_ff;
   logic [7:0]          reg_rdata_ff;
   lvc_pkg::lvc_meas_t  state_ff;
   lvc_pkg::lvc_meas_t  nxt_state;
   logic [31:0]         timer_ff;
   logic [31:0]         nxt_timer;
   logic                sense_start_ff;
   logic [7:0]          drive_code_ff;
   logic [7:0]          nxt_drive_code;
   logic [13:0]         drive_mv_ff;
   logic [13:0]         nxt_drive_mv;
   lvc_pkg::lvc_pump_t  pump_ff;
   logic [31:0]         pump_div_ff;
   logic [7:0]          nxt_temp;

   function automatic logic hit(input logic [2:0] a, input logic [2:0] r);
      return a == r;
   endfunction

   wire wr_ctrl = reg_write && hit(reg_addr, lvc_pkg::REG_CTRL);
   wire wr_volt = reg_write && hit(reg_addr, lvc_pkg::REG_VOLT);

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         ctrl_ff                    <=
            lvc_pkg::lvc_ctrl_t'(lvc_pkg::CTRL_RESET);
         programmed_voltage_code_ff <= lvc_pkg::VOLT_RESET;
      end else begin
         if (wr_ctrl)
            ctrl_ff <=
               lvc_pkg::lvc_ctrl_t'(reg_wdata[lvc_pkg::CTRL_WIDTH-1:0]);
         if (wr_volt)
            programmed_voltage_code_ff <= reg_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // temperature offset and drive code
   // offset uses unit slope: two's complement of code minus 20 degrees
   wire signed [9:0] temp_diff = $signed({2'b00, temperature_code_ff})
                               - $signed({2'b00, lvc_pkg::TEMP_RESET});
   wire [7:0] temperature_offset_code =
      (temp_diff > 10'sh07f) ? 8'h7f : temp_diff[7:0];
   // external supply suppresses compensation even with comp_en set
   wire comp_active = ctrl_ff.comp_en && !ctrl_ff.ext_supply;
   wire signed [9:0] offset_used =
      comp_active ? {{2{temperature_offset_code[7]}}, temperature_offset_code}
                  : 10'sh000;
   wire signed [9:0] drive_sum =
      $signed({2'b00, programmed_voltage_code_ff}) + offset_used;
   wire [7:0] sum_clamped =
      (drive_sum < 10'sh000) ? 8'h00 :
      (drive_sum > 10'sh0ff) ? 8'hff : drive_sum[7:0];
   wire cap_active = sum_clamped > lvc_pkg::DRIVE_CAP_CODE;

   // regulator target frozen while the supply is external
   assign nxt_drive_code = ctrl_ff.ext_supply ? drive_code_ff :
      (cap_active ? lvc_pkg::DRIVE_CAP_CODE : sum_clamped);
   assign nxt_drive_mv = 14'(nxt_drive_code) * 14'(lvc_pkg::LCD_DRIVE_VOLTAGE_STEP_MV)
                       + 14'(lvc_pkg::LCD_DRIVE_VOLTAGE_BASE_MV);

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         drive_code_ff <= 8'h00;
         drive_mv_ff   <= 14'(lvc_pkg::LCD_DRIVE_VOLTAGE_BASE_MV);
      end else begin
         drive_code_ff <= nxt_drive_code;
         drive_mv_ff   <= nxt_drive_mv;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // charge pump control
   // half rate doubles the divider, halving drive capability
   wire [31:0] pump_limit = ctrl_ff.freq_sel ? 32'(2 * PUMP_DIV - 1)
                                             : 32'(PUMP_DIV - 1);
   wire pump_tick = pump_div_ff >= pump_limit;

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         pump_ff     <= '0;
         pump_div_ff <= 32'h0;
      end else begin
         pump_ff.enable            <= ctrl_ff.pump_en;
         pump_ff.multiplier_select <= ctrl_ff.mult_sel;
         pump_ff.frequency_select  <= ctrl_ff.freq_sel;
         pump_div_ff <= (pump_tick || !ctrl_ff.pump_en) ? 32'h0
                                                        : pump_div_ff + 32'h1;
         if (!ctrl_ff.pump_en)
            pump_ff.clk <= 1'b0;
         else if (pump_tick)
            pump_ff.clk <= !pump_ff.clk;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // temperature measurement sequencer
   wire conv_done = (state_ff == lvc_pkg::LVC_CONV) &&
                    (timer_ff == 32'(MEAS_CYC - 1));
   wire wait_done = (state_ff == lvc_pkg::LVC_WAIT) &&
                    (timer_ff == 32'(INTERVAL_CYC - 1));

   always_comb begin
      nxt_state = state_ff;
      nxt_timer = timer_ff + 32'h1;
      case (state_ff)
         lvc_pkg::LVC_IDLE: begin
            nxt_timer = 32'h0;
            if (ctrl_ff.meas_en)
               nxt_state = lvc_pkg::LVC_CONV;
         end
         lvc_pkg::LVC_CONV: begin
            if (conv_done) begin
               nxt_state = lvc_pkg::LVC_WAIT;
               nxt_timer = 32'h0;
            end
         end
         lvc_pkg::LVC_WAIT: begin
            if (wait_done) begin
               nxt_state = lvc_pkg::LVC_CONV;
               nxt_timer = 32'h0;
            end
         end
         default: begin
            nxt_state = lvc_pkg::LVC_IDLE;
            nxt_timer = 32'h0;
         end
      endcase
      if (!ctrl_ff.meas_en) begin
         nxt_state = lvc_pkg::LVC_IDLE;
         nxt_timer = 32'h0;
      end
   end

   wire conv_begin = ctrl_ff.meas_en && (nxt_state == lvc_pkg::LVC_CONV) &&
                     (state_ff != lvc_pkg::LVC_CONV);

   // filter: first-order step toward each new sample
   wire signed [9:0] filt_err =
      $signed({2'b00, sense_value}) - $signed({2'b00, temperature_code_ff});
   wire signed [9:0] filt_next = $signed({2'b00, temperature_code_ff})
                               + (filt_err >>> lvc_pkg::FILTER_SHIFT);
   assign nxt_temp = ctrl_ff.filter_en ? filt_next[7:0]
                                       : sense_value;

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         state_ff            <= lvc_pkg::LVC_IDLE;
         timer_ff            <= 32'h0;
         sense_start_ff      <= 1'b0;
         temperature_code_ff <= lvc_pkg::TEMP_RESET;
      end else begin
         state_ff       <= nxt_state;
         timer_ff       <= nxt_timer;
         sense_start_ff <= conv_begin;
         if (conv_done)
            temperature_code_ff <= nxt_temp;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data
   wire [7:0] status_word = {6'h00, cap_active,
                             state_ff == lvc_pkg::LVC_CONV};
   wire [7:0] rd_mux =
      hit(reg_addr, lvc_pkg::REG_CTRL)   ? {1'b0, ctrl_ff} :
      hit(reg_addr, lvc_pkg::REG_VOLT)   ? programmed_voltage_code_ff :
      hit(reg_addr, lvc_pkg::REG_TEMP)   ? temperature_code_ff :
      hit(reg_addr, lvc_pkg::REG_OFFS)   ? temperature_offset_code :
      hit(reg_addr, lvc_pkg::REG_DRIVE)  ? drive_code_ff :
      hit(reg_addr, lvc_pkg::REG_STATUS) ? status_word : 8'h00;

   always_ff @(posedge mclk) begin
      if (!reset_n)
         reg_rdata_ff <= 8'h00;
      else
         reg_rdata_ff <= reg_read ? rd_mux : 8'h00;
   end

   assign reg_rdata         = reg_rdata_ff;
   assign sense_start       = sense_start_ff;
   assign pump_ctrl         = pump_ff;
   assign drive_code        = drive_code_ff;
   assign lcd_drive_voltage = drive_mv_ff;

   ////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_ctrl_write;
      reg_write && reg_addr == lvc_pkg::REG_CTRL;
   endsequence

   a_pump_enable_follow: assert property (
      @(posedge mclk) disable iff (!reset_n)
      s_ctrl_write ##2 1'b1 |->
         pump_ctrl.enable == $past(reg_wdata[lvc_pkg::CTRL_PUMP_EN], 2))
      else $error("pump enable does not follow control write");

   a_mult_select_follow: assert property (
      @(posedge mclk) disable iff (!reset_n)
      s_ctrl_write ##2 1'b1 |->
         pump_ctrl.multiplier_select ==
            $past(reg_wdata[lvc_pkg::CTRL_MULT], 2))
      else $error("multiplier select does not follow control write");

   a_drive_cap_limit: assert property (
      @(posedge mclk) disable iff (!reset_n)
      drive_code <= lvc_pkg::DRIVE_CAP_CODE)
      else $error("drive code above the voltage cap");

   a_drive_mv_scale: assert property (
      @(posedge mclk) disable iff (!reset_n)
      lcd_drive_voltage == 14'(drive_code) * 14'(lvc_pkg::LCD_DRIVE_VOLTAGE_STEP_MV)
                           + 14'(lvc_pkg::LCD_DRIVE_VOLTAGE_BASE_MV))
      else $error("drive voltage not code times step plus base");

   a_no_comp_plain: assert property (
      @(posedge mclk) disable iff (!reset_n)
      !ctrl_ff.comp_en && !ctrl_ff.ext_supply |=>
         drive_code ==
            (($past(programmed_voltage_code_ff) > lvc_pkg::DRIVE_CAP_CODE) ?
             lvc_pkg::DRIVE_CAP_CODE : $past(programmed_voltage_code_ff)))
      else $error("offset applied with compensation off");

   a_ext_drive_hold: assert property (
      @(posedge mclk) disable iff (!reset_n)
      ctrl_ff.ext_supply |=> $stable(drive_code))
      else $error("drive code moved with external supply");

   a_sum_low_clamp: assert property (
      @(posedge mclk) disable iff (!reset_n)
      !ctrl_ff.ext_supply && drive_sum < 10'sd0 |=> drive_code == 8'h00)
      else $error("negative sum did not clamp to zero");

   a_conv_to_wait: assert property (
      @(posedge mclk) disable iff (!reset_n)
      conv_done && ctrl_ff.meas_en |=> state_ff == lvc_pkg::LVC_WAIT)
      else $error("conversion did not end on its count");

   a_raw_bypass: assert property (
      @(posedge mclk) disable iff (!reset_n)
      conv_done && !ctrl_ff.filter_en |=>
         temperature_code_ff == $past(sense_value))
      else $error("raw temperature not taken with filter off");

   a_temp_reset_val: assert property (
      @(posedge mclk) disable iff (!reset_n)
      $past(!reset_n) |-> temperature_code_ff == 8'h40 && drive_code == 8'h00)
      else $error("temperature code not at reset value");

   a_pump_toggle_rate: assert property (
      @(posedge mclk) disable iff (!reset_n)
      ctrl_ff.pump_en && $past(ctrl_ff.pump_en) && $changed(pump_ctrl.clk) |->
         $past(pump_div_ff) == $past(pump_limit))
      else $error("pump clock toggled off its divider count");

   a_sense_single_pulse: assert property (
      @(posedge mclk) disable iff (!reset_n)
      sense_start |=> !sense_start)
      else $error("conversion start longer than one cycle");

   // clearing the enable must abort at once, no late start pulse
   a_meas_off_idle: assert property (
      @(posedge mclk) disable iff (!reset_n)
      !ctrl_ff.meas_en |=> state_ff == lvc_pkg::LVC_IDLE && !sense_start)
      else $error("sequencer not idle with measurement off");

   sequence s_temp_read;
      reg_read && reg_addr == lvc_pkg::REG_TEMP;
   endsequence

   a_temp_read_path: assert property (
      @(posedge mclk) disable iff (!reset_n)
      s_temp_read |=> reg_rdata == $past(temperature_code_ff))
      else $error("temperature code not returned on read");

   a_rdata_idle_zero: assert property (
      @(posedge mclk) disable iff (!reset_n)
      !reg_read |=> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");

endmodule // lvc_top

// ==== test/lvc_sensor_model.sv ====
// lvc_sensor_model: temperature sensor stand-in on the conversion port
`timescale 1ns/1ns
module lvc_sensor_model #(
   parameter int unsigned HOLD = 12
) (
   // clock
   input  wire logic       mclk,
   // conversion handshake
   input  wire logic       sense_start,
   input  wire logic [7:0] temp_in,
   output logic [7:0]      sense_value
);
   int unsigned left = 0;
   logic [7:0]  held = 8'h00;

   // sample is latched at conversion start and held through it
   always @(posedge mclk) begin
      if (sense_start) begin
         left <= HOLD;
         held <= temp_in;
      end else if (left != 0) begin
         left <= left - 1;
      end
   end

   // no valid sample outside a conversion: drive the inverse, not stale data
   assign sense_value = (left != 0) ? held : ~held;
endmodule // lvc_sensor_model

// ==== test/tb_top.sv ====
// tb_top: self-checking bench for the drive-voltage control block
`timescale 1ns/1ns
module tb_top;
   localparam int MC = 8;
   localparam int IC = 20;
   logic mclk = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00, sensor_temp = 8'h00, rd_v, nv;
   logic [7:0] reg_rdata, sense_value, drive_code;
   logic [13:0] lcd_drive_voltage;
   logic sense_start;
   lvc_pkg::lvc_pump_t pump_ctrl;
   int miscompares = 0, tests_run = 0;

   always #2 mclk = ~mclk;

   lvc_top #(.MEAS_CYC(MC), .INTERVAL_CYC(IC), .PUMP_DIV(2)) uut (
      .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .sense_start(sense_start),
      .sense_value(sense_value), .pump_ctrl(pump_ctrl),
      .drive_code(drive_code), .lcd_drive_voltage(lcd_drive_voltage));
   lvc_sensor_model #(.HOLD(MC + 4)) sensor (.mclk(mclk),
      .sense_start(sense_start), .temp_in(sensor_temp),
      .sense_value(sense_value));

   ////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_write <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge mclk);
      reg_write <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_read <= 1'b1; reg_addr <= a;
      @(posedge mclk);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic do_reset();
      reset_n <= 1'b0;
      repeat (16) @(posedge mclk);
      reset_n <= 1'b1;
   endtask
   task automatic check_drive(input int code);
      check({8'h00, drive_code}, 16'(code), "drive code");
      check({2'b00, lcd_drive_voltage}, 16'(code * 30 + 3000), "mv");
   endtask
   // polls the temperature code until it moves away from old
   task automatic wait_change(input logic [7:0] old, output logic [7:0] v);
      for (int i = 0; i < 300; i++) begin
         rd(lvc_pkg::REG_TEMP, v);
         if (v !== old) return;
      end
      miscompares++;
      $display("[FAIL] %0t temperature code never updated", $time);
      summarize();
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      check_drive(0);
      check({12'h000, pump_ctrl}, 16'h0000, "pump at reset");
      rd(lvc_pkg::REG_VOLT, rd_v);
      check({8'h0, rd_v}, 16'h00, "volt");
      @(posedge mclk);
      #1;
      check({8'h0, reg_rdata}, 16'h00, "read data idle");
      wr(lvc_pkg::REG_TEMP, 8'h11);
      rd(lvc_pkg::REG_TEMP, rd_v);
      check({8'h0, rd_v}, 16'h40, "temp");
      rd(3'h6, rd_v);
      check({8'h0, rd_v}, 16'h00, "unmapped read");
   endtask
   task automatic t_pump();
      int cnt;
      int e;
      logic prev;
      for (int i = 0; i < 8; i++) begin
         wr(lvc_pkg::REG_CTRL, 8'(i));
         check({13'h0, pump_ctrl[2:0]}, 16'(i), "bits");
         cnt = 0;
         prev = pump_ctrl.clk;
         for (int c = 0; c < 64; c++) begin
            @(posedge mclk);
            #1;
            if (pump_ctrl.clk !== prev)
               cnt++;
            prev = pump_ctrl.clk;
         end
         // halved pump rate gives half the clock edges
         e = (i % 2 == 0) ? 0 : ((i >= 4) ? 16 : 32);
         check(16'(cnt >= e - 1 && cnt <= e + 1), 16'h1, "clk");
      end
      wr(lvc_pkg::REG_CTRL, 8'h00);
   endtask
   task automatic t_volt();
      int vals[5] = '{8'h00, 8'h64, 8'hc8, 8'hc9, 8'hff};
      foreach (vals[i]) begin
         wr(lvc_pkg::REG_VOLT, 8'(vals[i]));
         check_drive(vals[i] > 200 ? 200 : vals[i]);
      end
   endtask
   task automatic t_comp();
      sensor_temp <= 8'h20;
      wr(lvc_pkg::REG_VOLT, 8'h10);
      wr(lvc_pkg::REG_CTRL, 8'h28);
      rd(lvc_pkg::REG_CTRL, rd_v);
      check({8'h0, rd_v}, 16'h28, "ctrl readback");
      wait_change(8'h40, nv);
      check({8'h0, nv}, 16'h20, "raw temp");
      @(posedge mclk);
      #1;
      check_drive(0);
      rd(lvc_pkg::REG_OFFS, rd_v);
      check({8'h0, rd_v}, 16'he0, "offset");
      sensor_temp <= 8'hc0;
      // code chosen so the drive stays above the pump supply
      wr(lvc_pkg::REG_VOLT, 8'h30);
      wait_change(8'h20, nv);
      @(posedge mclk);
      #1;
      check_drive(8'hb0 - 1);
      wr(lvc_pkg::REG_VOLT, 8'hf0);
      check_drive(200);
      rd(lvc_pkg::REG_DRIVE, rd_v);
      check({8'h0, rd_v}, 16'hc8, "drive reg");
      rd(lvc_pkg::REG_STATUS, rd_v);
      check({15'h0, rd_v[1]}, 16'h1, "cap flag");
      wr(lvc_pkg::REG_VOLT, 8'h30);
      wr(lvc_pkg::REG_CTRL, 8'h08);
      check_drive(8'h30);
      // external supply: host keeps the pump off
      wr(lvc_pkg::REG_CTRL, 8'h68);
      wr(lvc_pkg::REG_VOLT, 8'h50);
      check_drive(8'h30);
      check({15'h0, pump_ctrl.enable}, 16'h0, "pump off");
   endtask
   task automatic t_filter();
      int gap;
      logic gap_ok;
      do_reset();
      sensor_temp <= 8'h80;
      wr(lvc_pkg::REG_CTRL, 8'h18);
      wait_change(8'h40, nv);
      check({8'h0, nv}, 16'h50, "filter step 1");
      wait_change(8'h50, nv);
      check({8'h0, nv}, 16'h5c, "filter step 2");
      gap = 0;
      // sample off the edge so the start pulse is settled
      for (int i = 0; i < 200 && sense_start !== 1'b1; i++) begin
         @(posedge mclk);
         #1;
      end
      @(posedge mclk);
      #1;
      for (int i = 0; i < 200 && sense_start !== 1'b1; i++) begin
         @(posedge mclk);
         #1;
         gap++;
      end
      if (sense_start !== 1'b1) begin
         miscompares++;
         $display("[FAIL] %0t conversion start never seen", $time);
         summarize();
      end
      // start pulses MC + IC cycles apart, less the edge skipped before counting
      gap_ok = gap >= MC + IC - 1 && gap <= MC + IC + 3;
      check({15'h0, gap_ok}, 16'h1, "gap");
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      do_reset();
      @(posedge mclk); #1;
      t_reset();
      t_pump();
      t_volt();
      t_comp();
      t_filter();
      summarize();
   end
endmodule // tb_top
